/* File: design/tsm_pkg.sv */
package tsm_pkg;

	// ***************************************************************
	// clocking and long times
	// ***************************************************************
	localparam int unsigned CLK_NS        = 8;
	localparam int unsigned POLL_SLOW_NS  = 1_000_000_000;
	localparam int unsigned POLL_FAST_NS  = 10_000_000;
	localparam int unsigned POLL_SLOW_DEF = POLL_SLOW_NS / CLK_NS;
	localparam int unsigned POLL_FAST_DEF = POLL_FAST_NS / CLK_NS;
	localparam int unsigned SMP_NS [8] = '{28_000, 56_000, 168_000, 280_000,
		816_000, 2_280_000, 6_220_000, 11_790_000};
	localparam int unsigned SMP_CYC_DEF [8] = '{SMP_NS[0] / CLK_NS, SMP_NS[1] / CLK_NS,
		SMP_NS[2] / CLK_NS, SMP_NS[3] / CLK_NS, SMP_NS[4] / CLK_NS,
		SMP_NS[5] / CLK_NS, SMP_NS[6] / CLK_NS, SMP_NS[7] / CLK_NS};
	localparam int unsigned POLL_W = 27;
	localparam int unsigned IVAL_W = 21;

	// ***************************************************************
	// register indices (byte address is four times the index)
	// ***************************************************************
	localparam logic [5:0] IDX_CTRL = 6'h1a;
	localparam logic [5:0] IDX_ALT  = 6'h1b;
	localparam logic [5:0] IDX_STS  = 6'h1c;
	localparam logic [5:0] IDX_MSK  = 6'h1d;
	localparam logic [5:0] IDX_MODE = 6'h1e;

	// ***************************************************************
	// field positions and reset values
	// ***************************************************************
	localparam int unsigned CTRL_ACC_LSB = 13;
	localparam int unsigned CTRL_THR_LSB = 8;
	localparam int unsigned CTRL_IEN     = 7;
	localparam int unsigned CTRL_TINT    = 6;
	localparam int unsigned CTRL_MAN     = 5;
	localparam int unsigned ALT_AVG_LSB  = 11;
	localparam int unsigned ALT_RATE_LSB = 8;
	localparam int unsigned MODE_LSB     = 4;
	localparam logic [1:0] ACC_RST   = 2'h0;
	localparam logic [4:0] THR_RST   = 5'h19;
	localparam logic [1:0] AVG_RST   = 2'h1;
	localparam logic [2:0] RATE_RST  = 3'h4;
	localparam logic [1:0] MODE_MAN  = 2'h2;
	localparam logic [7:0] THR_MULT  = 8'h05;
	localparam logic [3:0] AVG_SH_LO = 4'h9;
	localparam int unsigned EV_HOT   = 0;
	localparam int unsigned EV_DONE  = 1;
	localparam int unsigned EV_N     = 2;

	typedef enum logic [2:0] {
		TSM_IDLE = 3'b001,
		TSM_ACQ  = 3'b010,
		TSM_READ = 3'b100
	} tsm_state_e;

endpackage : tsm_pkg

/* File: design/tsm_top.sv */
// Summary of operation
// - poll 1 s, 10 ms, or never
// - threshold degrees are five times field minus 25
// - interrupt forwarded only when enable set
// - status latches when temperature reaches threshold
// - manual bit drives sensor enable in mode 10
// - coarse field shows value bits five to one
// - averaging depth 2^9 to 2^15, reset 01
// - sampling interval from eight codes, reset 100
// - alternative reading is degrees plus 25
`timescale 1ns/1ps
`default_nettype none
module tsm_top #(
	parameter int unsigned POLL_SLOW_CYC = tsm_pkg::POLL_SLOW_DEF,
	parameter int unsigned POLL_FAST_CYC = tsm_pkg::POLL_FAST_DEF,
	parameter int unsigned SMP_CYC [8]   = tsm_pkg::SMP_CYC_DEF
) (
	input  wire logic        pclk,       // bus and block clock
	input  wire logic        presetn,    // asynchronous reset, active low
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb access phase
	input  wire logic        pwrite,     // apb direction
	input  wire logic [7:0]  paddr,      // apb byte address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic      [31:0] prdata,     // apb read data
	output logic             pready,     // apb ready
	output logic             pslverr,    // apb error on unmapped address
	output logic             sense_en,   // sensor enable, high acquires
	input  wire logic [7:0]  sense_data, // sensor raw reading
	output logic             temp_irq,   // over-temperature interrupt
	output logic             irq         // masked event interrupt
);
	import tsm_pkg::*;

	// ***************************************************************
	// functions
	// ***************************************************************
	function automatic logic [3:0] avg_shift(input logic [1:0] code);
		avg_shift = AVG_SH_LO + {1'b0, code, 1'b0};
	endfunction : avg_shift

	function automatic logic match(input logic [7:0] a, input logic [5:0] idx);
		match = (a[7:2] == idx);
	endfunction : match

	// ***************************************************************
	// state
	// ***************************************************************
	tsm_state_e          st_q, st_d;
	logic [1:0]          acc_q;
	logic [4:0]          thr_q;
	logic                ien_q, tint_q, man_q, man_old_q;
	logic [1:0]          avg_q;
	logic [2:0]          rate_q;
	logic [1:0]          mode_q;
	logic [EV_N-1:0]     sts_q, msk_q;
	logic [7:0]          temp_q;
	logic                valid_q, hot_old_q;
	logic [POLL_W-1:0]   poll_q;
	logic [IVAL_W-1:0]   ival_q;
	logic [15:0]         smp_q;
	logic [22:0]         sum_q;
	logic                rdy_q, err_q, sen_q, tirq_q, irq_q;
	logic [31:0]         rd_q;

	// ***************************************************************
	// bus decode
	// ***************************************************************
	wire logic acc_ph   = psel & penable;
	wire logic xfer     = acc_ph & rdy_q;
	wire logic wr       = xfer & pwrite;
	wire logic rd       = xfer & ~pwrite;
	wire logic hit_ctrl = match(paddr, IDX_CTRL);
	wire logic hit_alt  = match(paddr, IDX_ALT);
	wire logic hit_sts  = match(paddr, IDX_STS);
	wire logic hit_msk  = match(paddr, IDX_MSK);
	wire logic hit_mode = match(paddr, IDX_MODE);
	wire logic mapped   = hit_ctrl | hit_alt | hit_sts | hit_msk | hit_mode;
	wire logic wr_ctrl  = wr & hit_ctrl;
	wire logic wr_alt   = wr & hit_alt;
	wire logic rd_ctrl  = rd & hit_ctrl;

	wire logic [15:0] ctrl_rd = {1'b0, acc_q, thr_q, ien_q, tint_q, man_q, temp_q[5:1]};
	wire logic [15:0] alt_rd  = {3'b000, avg_q, rate_q, temp_q};
	wire logic [31:0] rd_mux  = hit_ctrl ? {16'h0000, ctrl_rd} :
		hit_alt  ? {16'h0000, alt_rd} :
		hit_sts  ? {30'h0, sts_q} :
		hit_msk  ? {30'h0, msk_q} :
		hit_mode ? {26'h0, mode_q, 4'h0} : 32'h0000_0000;

	// ***************************************************************
	// measurement sequencing
	// ***************************************************************
	wire logic manual  = (mode_q == MODE_MAN);
	wire logic no_poll = acc_q[1];
	wire logic [POLL_W-1:0] poll_lim = acc_q[0] ? POLL_W'(POLL_FAST_CYC - 1) :
		POLL_W'(POLL_SLOW_CYC - 1);
	wire logic poll_tick = ~no_poll & ~manual & (poll_q >= poll_lim);
	wire logic [IVAL_W-1:0] ival_lim = IVAL_W'(SMP_CYC[rate_q] - 1);
	wire logic ival_end = (ival_q >= ival_lim);
	wire logic [3:0]  sh       = avg_shift(avg_q);
	wire logic [15:0] smp_last = (16'h0001 << sh) - 16'h0001;
	wire logic [22:0] sum_nx   = sum_q + {15'h0000, sense_data};
	wire logic [22:0] avg_full = sum_nx >> sh;
	wire logic [7:0]  avg_w    = avg_full[7:0];
	wire logic done_auto = (st_q == TSM_READ) & (smp_q == smp_last);
	wire logic man_read  = manual & man_old_q & ~man_q;
	wire logic [7:0] thr_x5 = {3'b000, thr_q} * THR_MULT;
	wire logic hot = valid_q & (temp_q >= thr_x5);
	wire logic [EV_N-1:0] ev = {done_auto | man_read, hot & ~hot_old_q};

	always_comb begin
		st_d = st_q;
		case (st_q)
			TSM_IDLE: begin
				if (poll_tick) begin
					st_d = TSM_ACQ;
				end
			end
			TSM_ACQ: begin
				if (manual) begin
					st_d = TSM_IDLE;
				end else if (ival_end) begin
					st_d = TSM_READ;
				end
			end
			TSM_READ: begin
				if (manual || done_auto) begin
					st_d = TSM_IDLE;
				end else begin
					st_d = TSM_ACQ;
				end
			end
			default: begin
				st_d = TSM_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= TSM_IDLE;
			poll_q    <= '0;
			ival_q    <= '0;
			smp_q     <= '0;
			sum_q     <= '0;
			man_old_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			poll_q    <= (poll_tick || no_poll || manual) ? '0 : poll_q + 1'b1;
			ival_q    <= (st_q == TSM_ACQ && !ival_end) ? ival_q + 1'b1 : '0;
			smp_q     <= (st_q == TSM_IDLE) ? '0 :
				(st_q == TSM_READ) ? smp_q + 16'h0001 : smp_q;
			sum_q     <= (st_q == TSM_IDLE) ? '0 : (st_q == TSM_READ) ? sum_nx : sum_q;
			man_old_q <= man_q;
		end
	end

	// ***************************************************************
	// results and flags
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_q    <= '0;
			valid_q   <= 1'b0;
			hot_old_q <= 1'b0;
			tint_q    <= 1'b0;
			sts_q     <= '0;
		end else begin
			if (done_auto) begin
				temp_q  <= avg_w;
				valid_q <= 1'b1;
			end else if (man_read) begin
				temp_q  <= sense_data;
				valid_q <= 1'b1;
			end
			hot_old_q <= hot;
			tint_q    <= hot | (tint_q & ~rd_ctrl);
			sts_q     <= ev | (sts_q & ~((wr && hit_sts) ? pwdata[EV_N-1:0] : '0));
		end
	end

	// ***************************************************************
	// register writes
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q  <= ACC_RST;
			thr_q  <= THR_RST;
			ien_q  <= 1'b0;
			man_q  <= 1'b0;
			avg_q  <= AVG_RST;
			rate_q <= RATE_RST;
			mode_q <= '0;
			msk_q  <= '0;
		end else begin
			if (wr_ctrl) begin
				acc_q <= pwdata[CTRL_ACC_LSB +: 2];
				thr_q <= pwdata[CTRL_THR_LSB +: 5];
				ien_q <= pwdata[CTRL_IEN];
				man_q <= pwdata[CTRL_MAN];
			end
			if (wr_alt) begin
				avg_q  <= pwdata[ALT_AVG_LSB +: 2];
				rate_q <= pwdata[ALT_RATE_LSB +: 3];
			end
			if (wr && hit_mode) begin
				mode_q <= pwdata[MODE_LSB +: 2];
			end
			if (wr && hit_msk) begin
				msk_q <= pwdata[EV_N-1:0];
			end
		end
	end

	// ***************************************************************
	// registered outputs
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_q  <= 1'b0;
			err_q  <= 1'b0;
			rd_q   <= '0;
			sen_q  <= 1'b0;
			tirq_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			rdy_q  <= acc_ph & ~rdy_q;
			err_q  <= acc_ph & ~rdy_q & ~mapped;
			rd_q   <= (acc_ph && !rdy_q && !pwrite) ? rd_mux : rd_q;
			sen_q  <= manual ? man_q : (st_d == TSM_ACQ);
			tirq_q <= tint_q & ien_q;
			irq_q  <= |(sts_q & msk_q);
		end
	end

	assign prdata   = rd_q;
	assign pready   = rdy_q;
	assign pslverr  = err_q;
	assign sense_en = sen_q;
	assign temp_irq = tirq_q;
	assign irq      = irq_q;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_acq_start;
		!manual ##1 (st_q == TSM_ACQ) && $past(st_q) == TSM_IDLE;
	endsequence

	sequence s_acq_hold;
		(st_q == TSM_ACQ) [*8];
	endsequence

	sequence s_ctrl_read;
		rd_ctrl && !hot;
	endsequence

	AST_MAN_ENABLE: assert property (manual ##1 manual |-> sense_en == $past(man_q))
		else $error("sense enable does not follow manual bit");
	AST_TEMP_IRQ: assert property (##1 temp_irq == $past(tint_q && ien_q))
		else $error("temp irq does not follow status and enable");
	AST_IRQ_MASKED: assert property (!ien_q ##1 !ien_q |-> !temp_irq)
		else $error("temp irq high while disabled");
	AST_TINT_SET: assert property (hot |=> tint_q)
		else $error("status did not latch on hot");
	AST_READ_CLEAR: assert property (s_ctrl_read |=> !tint_q)
		else $error("status not cleared by read");
	AST_NO_POLL: assert property (acc_q[1] && st_q == TSM_IDLE |=> st_q == TSM_IDLE)
		else $error("poll started while polling disabled");
	AST_ACQ_LEN: assert property (s_acq_start |-> s_acq_hold)
		else $error("acquire interval too short");
	AST_AVG_RESULT: assert property (done_auto |=> temp_q == $past(avg_w) && valid_q)
		else $error("average result not stored");
	AST_THR_CMP: assert property ($rose(tint_q) |-> $past(temp_q) >= $past(thr_x5))
		else $error("status set below threshold");
	AST_COARSE: assert property (rdy_q && !pwrite && $past(hit_ctrl) |->
		prdata[4:0] == $past(temp_q[5:1]))
		else $error("coarse field mismatch");
	AST_ALT_READ: assert property (rdy_q && !pwrite && $past(hit_alt) |->
		prdata[7:0] == $past(temp_q))
		else $error("alternative reading mismatch");

endmodule : tsm_top
`default_nettype wire

/* File: sim/tsm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tsm_top_tb;
	import tsm_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} tsm_row_s;
	localparam int unsigned SMP_T [8] = '{10, 11, 12, 13, 14, 15, 16, 17};
	logic        pclk       = 1'b0;
	logic        presetn    = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic [7:0]  sense_data = 8'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sense_en;
	logic        temp_irq;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          error_cnt  = 0;
	int          n_tests    = 0;
	int          c;
	tsm_row_s    rows [13]  = '{
		'{1'b0, 8'h68, 32'h0, 32'h1900, 1'b0}, '{1'b0, 8'h6c, 32'h0, 32'h0c00, 1'b0},
		'{1'b0, 8'h78, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h0, 1'b1},
		'{1'b1, 8'h00, 32'hffffffff, 32'h0, 1'b1}, '{1'b1, 8'h68, 32'h00007fff, 32'h0, 1'b0},
		'{1'b0, 8'h68, 32'h0, 32'h7fa0, 1'b0}, '{1'b1, 8'h6c, 32'h0700, 32'h0, 1'b0},
		'{1'b0, 8'h6c, 32'h0, 32'h0700, 1'b0}, '{1'b1, 8'h74, 32'h3, 32'h0, 1'b0},
		'{1'b0, 8'h74, 32'h0, 32'h3, 1'b0}, '{1'b1, 8'h78, 32'h20, 32'h0, 1'b0},
		'{1'b0, 8'h78, 32'h0, 32'h20, 1'b0}};

	always #4 pclk = ~pclk;

	tsm_top #(.POLL_SLOW_CYC(200), .POLL_FAST_CYC(50), .SMP_CYC(SMP_T)) tsm_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sense_en(sense_en), .sense_data(sense_data), .temp_irq(temp_irq), .irq(irq));

	// ***************************************************************
	// bus tasks and checks
	// ***************************************************************
	task automatic end_sim();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			end_sim();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask : rdc

	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask : waitc

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		waitc(2);
		presetn <= 1'b1;
		foreach (rows[k]) begin
			apb(rows[k].wr, rows[k].a, rows[k].d);
			if (!rows[k].wr) chk(rd, rows[k].x);
			chk({31'h0, er}, {31'h0, rows[k].e});
		end
		waitc(2);
		chk({31'h0, sense_en}, 32'h1);
		sense_data <= 8'h7d;
		apb(1'b1, 8'h68, 32'h5980);
		waitc(3);
		chk({31'h0, sense_en}, 32'h0);
		rdc(8'h6c, 32'h077d);
		rdc(8'h68, 32'h59de);
		rdc(8'h68, 32'h59de);
		chk({31'h0, temp_irq}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h68, 32'h5900);
		waitc(3);
		chk({31'h0, temp_irq}, 32'h0);
		sense_data <= 8'h10;
		apb(1'b1, 8'h68, 32'h59a0);
		apb(1'b1, 8'h68, 32'h5980);
		waitc(3);
		rdc(8'h68, 32'h59c8);
		rdc(8'h68, 32'h5988);
		waitc(2);
		chk({31'h0, temp_irq}, 32'h0);
		apb(1'b1, 8'h70, 32'h3);
		rdc(8'h70, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// auto polling at the fast rate, longest interval, shortest averaging
		sense_data <= 8'h7d;
		apb(1'b1, 8'h78, 32'h0);
		apb(1'b1, 8'h68, 32'h3f80);
		c = 0;
		while (sense_en !== 1'b1 && c < 60) begin
			@(posedge pclk);
			c++;
		end
		chk({31'h0, sense_en}, 32'h1);
		c = 0;
		while (sense_en === 1'b1 && c < 40) begin
			@(posedge pclk);
			c++;
		end
		chk(c, SMP_T[7]);
		c = 0;
		while (irq !== 1'b1 && c < 12000) begin
			@(posedge pclk);
			c++;
		end
		chk({31'h0, irq}, 32'h1);
		rdc(8'h6c, 32'h077d);
		apb(1'b1, 8'h74, 32'h0);
		waitc(3);
		chk({31'h0, irq}, 32'h0);
		// mid-run reset: registers return to reset values, slow polling resumes
		presetn <= 1'b0;
		waitc(2);
		presetn <= 1'b1;
		chk({31'h0, temp_irq}, 32'h0);
		rdc(8'h68, 32'h1900);
		c = 0;
		while (sense_en !== 1'b1 && c < 220) begin
			@(posedge pclk);
			c++;
		end
		chk({31'h0, sense_en}, 32'h1);
		end_sim();
	end
endmodule : tsm_top_tb
`default_nettype wire
